// ==== dbs_map.svh ====
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH

// ==========================================================
// Widths and depths
`define DBS_DATA_W 32
`define DBS_BASE_W 30
`define DBS_FIFO_DEPTH 16

// ==========================================================
// Outstanding byte counts
`define DBS_CNT_NONE 3'h0
`define DBS_CNT_BYTE 3'h1
`define DBS_CNT_LONG 3'h4

// ==========================================================
// Size output codes {hi, lo}
`define DBS_SIZE_BYTE 2'h1
`define DBS_SIZE_WORD 2'h2
`define DBS_SIZE_TRIPLE 2'h3
`define DBS_SIZE_LONG 2'h0

// ==========================================================
// Byte offsets {hi, lo}
`define DBS_OFS_ALIGNED 2'h0
`define DBS_OFS_HALF 2'h2
`define DBS_OFS_LAST 2'h3

// ==========================================================
// Acknowledge pair codes {hi_n, lo_n}, pins active low
`define DBS_ACK_WAIT 2'h3
`define DBS_ACK_P8 2'h2
`define DBS_ACK_P16 2'h1
`define DBS_ACK_P32 2'h0

`endif

// ==== dbs_pkg.sv ====
package dbs_pkg;

    // ======================================================
    // Operation kinds
    typedef enum logic [1:0] {
        DBS_OP_READ_LONG,
        DBS_OP_WRITE_BYTE,
        DBS_OP_RMW_BYTE
    } dbs_op_e;

    // ======================================================
    // Sequencer states
    typedef enum logic [1:0] {
        DBS_ST_IDLE,
        DBS_ST_CYC,
        DBS_ST_GAP
    } dbs_state_e;

    // ======================================================
    // Operand request
    typedef struct packed {
        dbs_op_e op;
        logic [29:0] base;
        logic [1:0] offset;
        logic [7:0] wdata;
    } dbs_req_s;

    typedef logic [3:0][7:0] dbs_operand_t;

endpackage : dbs_pkg

// ==== dbs_fifo.sv ====
`timescale 1ns/1ps

module dbs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    // Count is one bit wider than the pointers so full is distinct
    assign in_ready = (count_reg != (AW + 1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                        : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                        : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (ce) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
            end
        end
    end

endmodule : dbs_fifo

// ==== dbs_lane_mux.sv ====
`timescale 1ns/1ps
`include "dbs_map.svh"

// Overview of operation
// - low address outputs carry byte offset
// - upper address holds long word base
// - size shows remaining bytes; width from acks
// - port width re-evaluated on every cycle
// - start only long reads, byte writes/RMW
// - lane routing follows size and offset
// - 16-bit port: 00/00 then 10/10
// - narrow ack latches word, next cycle follows
// - 8-bit port: four cycles, sizes step down
// - writes drive all four lanes
// - any mix of port widths works
// - strobes shareable with companion master
// - size codes 01 byte ... 00 long
// - every operand starts assuming 32-bit port
module dbs_lane_mux #(
    parameter int FIFO_DEPTH = `DBS_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input dbs_pkg::dbs_req_s req,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_data,
    output logic [29:0] addr_base,
    output logic byte_offset_hi,
    output logic byte_offset_lo,
    output logic xfer_size_hi,
    output logic xfer_size_lo,
    output logic bus_cycle,
    output logic write_cycle,
    output logic rmw_lock,
    output logic bus_oe,
    output logic [31:0] data_out,
    output logic data_oe,
    input wire logic [31:0] data_in,
    input wire logic port_ack_hi_n,
    input wire logic port_ack_lo_n
);

    // ======================================================
    // Pin synchronisers
    logic [1:0] ack_s1_reg, ack_s2_reg;
    logic [31:0] data_s1_reg, data_s2_reg;

    // Data and acks ride the same two stages so they stay aligned
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_s1_reg <= `DBS_ACK_WAIT;
            ack_s2_reg <= `DBS_ACK_WAIT;
            data_s1_reg <= 32'h0;
            data_s2_reg <= 32'h0;
        end else if (ce) begin
            ack_s1_reg <= {port_ack_hi_n, port_ack_lo_n};
            ack_s2_reg <= ack_s1_reg;
            data_s1_reg <= data_in;
            data_s2_reg <= data_s1_reg;
        end
    end

    // ======================================================
    // State
    dbs_pkg::dbs_state_e st_reg, st_next;
    dbs_pkg::dbs_op_e kind_reg, kind_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [1:0] ofs_reg, ofs_next;
    logic [29:0] base_reg, base_next;
    logic [7:0] wbyte_reg, wbyte_next;
    logic wr_reg, wr_next;
    logic rmc_reg, rmc_next;
    logic cyc_reg, cyc_next;
    logic ready_reg, ready_next;
    logic [31:0] dout_reg, dout_next;
    logic doe_reg, doe_next;
    dbs_pkg::dbs_operand_t op_reg, op_next;

    logic is_byte, ack_done, ack32, ack16, push, fifo_in_ready;
    logic op_load;
    logic [7:0] load_byte;
    logic [2:0] acc;
    logic [3:0][7:0] cap;
    logic [3:0] hit;

    assign is_byte = (kind_reg != dbs_pkg::DBS_OP_READ_LONG);
    assign ack32 = (ack_s2_reg == `DBS_ACK_P32);
    assign ack16 = (ack_s2_reg == `DBS_ACK_P16);
    assign ack_done = (st_reg == dbs_pkg::DBS_ST_CYC)
                   && (ack_s2_reg != `DBS_ACK_WAIT);

    // Bytes the reported width can take at this offset
    function automatic logic [2:0] port_bytes(
        input logic [1:0] ack,
        input logic [1:0] ofs
    );
        case (ack)
            `DBS_ACK_P32: port_bytes = 3'h4 - {1'b0, ofs};
            `DBS_ACK_P16: port_bytes = ofs[0] ? 3'h1 : 3'h2;
            `DBS_ACK_P8: port_bytes = 3'h1;
            default: port_bytes = 3'h0;
        endcase
    endfunction : port_bytes

    // Write lane routing; a byte operand is copied everywhere
    function automatic logic [31:0] lane_mux(
        input dbs_pkg::dbs_operand_t op,
        input logic [1:0] ofs,
        input logic [2:0] cnt
    );
        logic [7:0] l1, l2;
        l1 = ofs[1] ? op[3] : op[1];
        l2 = (ofs == `DBS_OFS_LAST) ? op[3] : op[2];
        if (cnt == `DBS_CNT_BYTE) begin
            lane_mux = {4{op[3]}};
        end else begin
            lane_mux = {op[ofs], l1, l2, op[3]};
        end
    endfunction : lane_mux

    always_comb begin
        logic [2:0] pb;
        pb = port_bytes(ack_s2_reg, ofs_reg);
        acc = (pb < cnt_reg) ? pb : cnt_reg;
    end

    // ======================================================
    // Read capture, one slice per operand byte
    for (genvar gi = 0; gi < 4; gi++) begin : g_byte
        localparam logic [1:0] IDX = 2'(gi);
        logic [1:0] ai, lane;
        assign ai = is_byte ? ofs_reg : IDX;
        // Narrow ports live on the upper lanes
        assign lane = ack32 ? ai
                    : ack16 ? {1'b0, ai[0]} : 2'h0;
        assign cap[gi] = data_s2_reg[{~lane, 3'h0} +: 8];
        assign hit[gi] = is_byte ? (IDX == 2'h3)
                       : ({1'b0, IDX} >= {1'b0, ofs_reg})
                       && ({1'b0, IDX} < {1'b0, ofs_reg} + acc);
        assign op_next[gi] = (op_load && IDX == 2'h3) ? load_byte
                           : (ack_done && !wr_reg && hit[gi]) ? cap[gi]
                           : op_reg[gi];
    end

    // ======================================================
    // Sequencer
    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        cnt_next = cnt_reg;
        ofs_next = ofs_reg;
        base_next = base_reg;
        wbyte_next = wbyte_reg;
        wr_next = wr_reg;
        rmc_next = rmc_reg;
        cyc_next = cyc_reg;
        push = 1'b0;
        op_load = 1'b0;
        load_byte = req.wdata;
        case (st_reg)
            dbs_pkg::DBS_ST_IDLE: begin
                if (req_valid && ready_reg) begin
                    base_next = req.base;
                    kind_next = req.op;
                    wbyte_next = req.wdata;
                    cyc_next = 1'b1;
                    st_next = dbs_pkg::DBS_ST_CYC;
                    case (req.op)
                        dbs_pkg::DBS_OP_WRITE_BYTE: begin
                            cnt_next = `DBS_CNT_BYTE;
                            ofs_next = req.offset;
                            wr_next = 1'b1;
                            rmc_next = 1'b0;
                            op_load = 1'b1;
                        end
                        dbs_pkg::DBS_OP_RMW_BYTE: begin
                            cnt_next = `DBS_CNT_BYTE;
                            ofs_next = req.offset;
                            wr_next = 1'b0;
                            rmc_next = 1'b1;
                        end
                        default: begin
                            // Long reads are forced aligned, full size
                            kind_next = dbs_pkg::DBS_OP_READ_LONG;
                            cnt_next = `DBS_CNT_LONG;
                            ofs_next = `DBS_OFS_ALIGNED;
                            wr_next = 1'b0;
                            rmc_next = 1'b0;
                        end
                    endcase
                end
            end
            dbs_pkg::DBS_ST_CYC: begin
                if (ack_done) begin
                    cnt_next = cnt_reg - acc;
                    ofs_next = ofs_reg
                             + (is_byte ? 2'h0 : acc[1:0]);
                    cyc_next = 1'b0;
                    st_next = dbs_pkg::DBS_ST_GAP;
                end
            end
            dbs_pkg::DBS_ST_GAP: begin
                // Next cycle only after the slave drops its acks
                if (ack_s2_reg == `DBS_ACK_WAIT) begin
                    if (cnt_reg != `DBS_CNT_NONE) begin
                        cyc_next = 1'b1;
                        st_next = dbs_pkg::DBS_ST_CYC;
                    end else if (rmc_reg && !wr_reg) begin
                        push = 1'b1;
                        wr_next = 1'b1;
                        cnt_next = `DBS_CNT_BYTE;
                        op_load = 1'b1;
                        load_byte = wbyte_reg;
                        cyc_next = 1'b1;
                        st_next = dbs_pkg::DBS_ST_CYC;
                    end else begin
                        push = !wr_reg;
                        wr_next = 1'b0;
                        rmc_next = 1'b0;
                        st_next = dbs_pkg::DBS_ST_IDLE;
                    end
                end
            end
            default: begin
                st_next = dbs_pkg::DBS_ST_IDLE;
                cyc_next = 1'b0;
            end
        endcase
        // Room was reserved at accept, so a pending push blocks
        ready_next = (st_next == dbs_pkg::DBS_ST_IDLE)
                  && fifo_in_ready && !push;
        dout_next = lane_mux(op_next, ofs_next, cnt_next);
        doe_next = wr_next && cyc_next;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= dbs_pkg::DBS_ST_IDLE;
            kind_reg <= dbs_pkg::DBS_OP_READ_LONG;
            cnt_reg <= `DBS_CNT_NONE;
            ofs_reg <= `DBS_OFS_ALIGNED;
            base_reg <= 30'h0;
            wbyte_reg <= 8'h00;
            wr_reg <= 1'b0;
            rmc_reg <= 1'b0;
            cyc_reg <= 1'b0;
            ready_reg <= 1'b0;
            dout_reg <= 32'h0;
            doe_reg <= 1'b0;
            op_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            cnt_reg <= cnt_next;
            ofs_reg <= ofs_next;
            base_reg <= base_next;
            wbyte_reg <= wbyte_next;
            wr_reg <= wr_next;
            rmc_reg <= rmc_next;
            cyc_reg <= cyc_next;
            ready_reg <= ready_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            op_reg <= op_next;
        end
    end

    // ======================================================
    // Read data buffer
    dbs_fifo #(
        .WIDTH(`DBS_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        // Registered operand: a same-cycle reload must not leak in
        .in_data(op_reg),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    // ======================================================
    // Outputs
    assign req_ready = ready_reg;
    assign addr_base = base_reg;
    assign {byte_offset_hi, byte_offset_lo} = ofs_reg;
    assign {xfer_size_hi, xfer_size_lo} = cnt_reg[1:0];
    assign bus_cycle = cyc_reg;
    assign write_cycle = wr_reg;
    assign rmw_lock = rmc_reg;
    // Released when idle so strobes can be shared
    assign bus_oe = (st_reg != dbs_pkg::DBS_ST_IDLE);
    assign data_out = dout_reg;
    assign data_oe = doe_reg;

    // ======================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !ce);

    size_encode_a: assert property (
        cyc_reg |-> cnt_reg != `DBS_CNT_NONE
            && {xfer_size_hi, xfer_size_lo} == (cnt_reg == `DBS_CNT_LONG
            ? `DBS_SIZE_LONG : cnt_reg == 3'h3 ? `DBS_SIZE_TRIPLE
            : cnt_reg == 3'h2 ? `DBS_SIZE_WORD : `DBS_SIZE_BYTE))
        else $error("size outputs do not match remaining bytes");

    base_hold_a: assert property (
        (st_reg != dbs_pkg::DBS_ST_IDLE) ##1
        (st_reg != dbs_pkg::DBS_ST_IDLE) |-> $stable(addr_base))
        else $error("base address moved inside an operand");

    start_legal_a: assert property (
        st_reg == dbs_pkg::DBS_ST_IDLE ##1 cyc_reg |->
        (cnt_reg == `DBS_CNT_LONG && ofs_reg == `DBS_OFS_ALIGNED
            && !wr_reg) || cnt_reg == `DBS_CNT_BYTE)
        else $error("illegal first cycle of an operand");

    offset_sum_a: assert property (
        cyc_reg && !is_byte |->
        {1'b0, ofs_reg} + cnt_reg == `DBS_CNT_LONG)
        else $error("offset and remaining count disagree");

    write_lanes_a: assert property (
        cyc_reg && wr_reg |-> data_oe &&
        data_out == {4{op_reg[3]}})
        else $error("write lanes not driven with the byte");

    half_step_a: assert property (
        ack_done && ack16 && cnt_reg == `DBS_CNT_LONG |=>
        ofs_reg == `DBS_OFS_HALF && cnt_reg == 3'h2 ##[1:4] cyc_reg)
        else $error("16-bit port second cycle wrong");

    byte_step_a: assert property (
        ack_done && ack_s2_reg == `DBS_ACK_P8 |=>
        cnt_reg == $past(cnt_reg) - 3'h1)
        else $error("8-bit port did not take one byte");

    wide_done_a: assert property (
        ack_done && ack32 && cnt_reg == `DBS_CNT_LONG |=>
        cnt_reg == `DBS_CNT_NONE ##[1:4] push)
        else $error("32-bit port did not finish in one cycle");

    long_sixteen_c: cover property (
        ack_done && ack16 ##[1:8] ack_done && ack16);
    long_eight_c: cover property (
        cnt_reg == 3'h1 && ack_done && !is_byte);
    rmw_write_c: cover property (rmc_reg && wr_reg && cyc_reg);

endmodule : dbs_lane_mux

// ==== dbs_slave_model.sv ====
`timescale 1ns/1ps

module dbs_slave_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_cycle,
    input wire logic write_cycle,
    input wire logic [29:0] addr_base,
    input wire logic byte_offset_hi,
    input wire logic byte_offset_lo,
    input wire logic [31:0] data_out,
    input wire logic [1:0] width_sel,
    input wire logic [3:0] wait_cyc,
    output logic [31:0] data_in,
    output logic port_ack_hi_n,
    output logic port_ack_lo_n
);
    // ==========================================================
    // Storage and per-cycle state
    // Width codes: 0 = 32-bit, 1 = 16-bit, 2 = 8-bit, 3 = rotate 8/16/32
    logic [7:0] mem [32][4];
    logic [3:0] wait_cnt;
    logic [1:0] rot;
    logic [1:0] width;
    logic [1:0] ofs;
    logic [31:0] bus;
    logic served;

    function automatic logic [1:0] lane_of(input logic [1:0] wd,
                                           input logic [1:0] k);
        lane_of = (wd == 2'h0) ? k : ((wd == 2'h1) ? {1'b0, k[0]} : 2'h0);
    endfunction : lane_of

    initial begin
        for (int a = 0; a < 32; a++) begin
            for (int k = 0; k < 4; k++) begin
                mem[a][k] = {a[4:0], 1'b0, k[1:0]};
            end
        end
    end

    // ==========================================================
    // Port response
    always @(posedge clock) begin
        width = (width_sel == 2'h3) ? rot : width_sel;
        ofs = {byte_offset_hi, byte_offset_lo};
        if (!rst_n || width_sel != 2'h3) begin
            rot <= 2'h2;
        end
        if (!rst_n) begin
            port_ack_hi_n <= 1'b1;
            port_ack_lo_n <= 1'b1;
            data_in <= 32'h0;
            wait_cnt <= 4'h0;
            served <= 1'b0;
        end else if (!bus_cycle) begin
            // No pull-ups on the data pins: released lines show garbage
            port_ack_hi_n <= 1'b1;
            port_ack_lo_n <= 1'b1;
            data_in <= ~data_in;
            wait_cnt <= 4'h0;
            served <= 1'b0;
        end else if (!served && wait_cnt < wait_cyc) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else if (!served) begin
            served <= 1'b1;
            port_ack_hi_n <= (width == 2'h2);
            port_ack_lo_n <= (width == 2'h1);
            bus = ~data_in;
            for (int k = 0; k < 4; k++) begin
                if (width == 2'h0 || (width == 2'h1 && k[1] == ofs[1]) ||
                    k[1:0] == ofs) begin
                    bus[31 - 8 * lane_of(width, k[1:0]) -: 8] =
                        mem[addr_base[4:0]][k];
                end
            end
            if (write_cycle) begin
                // Only the one section this port owns is enabled
                mem[addr_base[4:0]][ofs] <=
                    data_out[31 - 8 * lane_of(width, ofs) -: 8];
            end else begin
                data_in <= bus;
            end
            if (width_sel == 2'h3) begin
                rot <= (rot == 2'h0) ? 2'h2 : rot - 2'h1;
            end
        end
    end
endmodule : dbs_slave_model

// ==== dbs_lane_mux_tb.sv ====
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
end

module dbs_lane_mux_tb;
    logic clock, rst_n, ce, req_valid, req_ready, rd_valid, rd_ready;
    logic [31:0] rd_data, data_out, data_in;
    logic [29:0] addr_base, exp_base;
    logic byte_offset_hi, byte_offset_lo, xfer_size_hi, xfer_size_lo;
    logic bus_cycle, write_cycle, rmw_lock, bus_oe, data_oe, bc_prev;
    logic port_ack_hi_n, port_ack_lo_n;
    dbs_pkg::dbs_req_s req;
    logic [1:0] width_sel;
    logic [3:0] wait_cyc;
    logic [7:0] exp_wdata;
    logic [5:0] log_q [$];
    int fail_count, num_checks, cycles;

    dbs_lane_mux #(.FIFO_DEPTH(16)) uut (.clock(clock), .rst_n(rst_n),
        .ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .addr_base(addr_base), .byte_offset_hi(byte_offset_hi),
        .byte_offset_lo(byte_offset_lo), .xfer_size_hi(xfer_size_hi),
        .xfer_size_lo(xfer_size_lo), .bus_cycle(bus_cycle),
        .write_cycle(write_cycle), .rmw_lock(rmw_lock), .bus_oe(bus_oe),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n));

    dbs_slave_model partner (.clock(clock), .rst_n(rst_n),
        .bus_cycle(bus_cycle), .write_cycle(write_cycle),
        .addr_base(addr_base), .byte_offset_hi(byte_offset_hi),
        .byte_offset_lo(byte_offset_lo), .data_out(data_out),
        .width_sel(width_sel), .wait_cyc(wait_cyc), .data_in(data_in),
        .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ==========================================================
    // Bus cycle monitor: {lock, write, size, offset} at each opening
    always @(posedge clock) begin
        bc_prev <= bus_cycle;
        if (rst_n && bus_cycle === 1'b1 && bc_prev !== 1'b1) begin
            log_q.push_back({rmw_lock, write_cycle, xfer_size_hi,
                             xfer_size_lo, byte_offset_hi, byte_offset_lo});
            `CHK("addr_base", exp_base, addr_base)
            `CHK("data_oe", write_cycle, data_oe)
            `CHK("bus_oe", 1'b1, bus_oe)
            if (write_cycle === 1'b1) begin
                `CHK("data_out", {4{exp_wdata}}, data_out)
            end
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("timeout reached");
            summarize();
        end
    end

    // ==========================================================
    // Shared helpers
    function automatic logic [31:0] word_of(input logic [29:0] b);
        for (int k = 0; k < 4; k++) begin
            word_of[8 * k +: 8] = {b[4:0], 1'b0, k[1:0]};
        end
    endfunction : word_of

    task automatic op(input dbs_pkg::dbs_op_e o, input logic [29:0] b,
                      input logic [1:0] f, input logic [7:0] wd,
                      output logic tk);
        int n;
        exp_base = b;
        exp_wdata = wd;
        log_q.delete();
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{o, b, f, wd};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        tk = (req_ready === 1'b1);
        req_valid <= 1'b0;
        repeat (2) @(posedge clock);
        n = 0;
        while (bus_oe !== 1'b0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        repeat (3) @(posedge clock);
    endtask : op

    task automatic chk_seq(input logic [5:0] e [4], input int n);
        `CHK("cycle_count", n, log_q.size())
        for (int i = 0; i < n && i < log_q.size(); i++) begin
            `CHK("cycle_code", e[i], log_q[i])
        end
    endtask : chk_seq

    task automatic pop(input logic [31:0] exp, input logic [31:0] mask);
        @(posedge clock);
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", exp, rd_data & mask)
        rd_ready <= 1'b1;
        @(posedge clock);
        rd_ready <= 1'b0;
    endtask : pop

    // ==========================================================
    // Scenarios
    task automatic t_widths();
        logic [5:0] seqs [3][4];
        int cnt [3];
        logic tk;
        seqs = '{'{6'h00, 6'h00, 6'h00, 6'h00}, '{6'h00, 6'h0A, 6'h00, 6'h00},
                 '{6'h00, 6'h0D, 6'h0A, 6'h07}};
        cnt = '{1, 2, 4};
        for (int w = 0; w < 3; w++) begin
            width_sel <= w[1:0];
            op(dbs_pkg::DBS_OP_READ_LONG, 30'(w + 1), 2'h0, 8'h00, tk);
            chk_seq(seqs[w], cnt[w]);
            pop(word_of(30'(w + 1)), 32'hFFFFFFFF);
        end
        $display("done t_widths");
    endtask : t_widths

    task automatic t_mixed();
        logic tk;
        width_sel <= 2'h3;
        op(dbs_pkg::DBS_OP_READ_LONG, 30'h5, 2'h0, 8'h00, tk);
        chk_seq('{6'h00, 6'h0D, 6'h0A, 6'h00}, 3);
        pop(word_of(30'h5), 32'hFFFFFFFF);
        $display("done t_mixed");
    endtask : t_mixed

    task automatic t_writes();
        logic tk;
        logic [7:0] b;
        for (int w = 0; w < 3; w++) begin
            width_sel <= w[1:0];
            for (int f = 0; f < 4; f++) begin
                op(dbs_pkg::DBS_OP_WRITE_BYTE, 30'(8 + w), f[1:0],
                   8'(8'hA0 + 4 * w + f), tk);
                chk_seq('{6'(6'h14 + f), 6'h00, 6'h00, 6'h00}, 1);
            end
            for (int k = 0; k < 4; k++) begin
                b = 8'(8'hA0 + 4 * w + k);
                `CHK("mem", b, partner.mem[8 + w][k])
            end
        end
        $display("done t_writes");
    endtask : t_writes

    task automatic t_rmw();
        logic tk;
        width_sel <= 2'h1;
        wait_cyc <= 4'h5;
        op(dbs_pkg::DBS_OP_RMW_BYTE, 30'h3, 2'h2, 8'h5A, tk);
        chk_seq('{6'h26, 6'h36, 6'h00, 6'h00}, 2);
        pop(32'h1A000000, 32'hFF000000);
        `CHK("mem", 8'h5A, partner.mem[3][2])
        wait_cyc <= 4'h0;
        $display("done t_rmw");
    endtask : t_rmw

    task automatic t_fifo();
        logic tk;
        width_sel <= 2'h0;
        // Consumer stalls: sixteen words fill the buffer
        for (int i = 0; i < 16; i++) begin
            op(dbs_pkg::DBS_OP_READ_LONG, 30'(16 + i), 2'h0, 8'h00, tk);
            `CHK("taken", 1'b1, tk)
        end
        op(dbs_pkg::DBS_OP_READ_LONG, 30'h0, 2'h0, 8'h00, tk);
        `CHK("taken", 1'b0, tk)
        for (int i = 0; i < 16; i++) begin
            pop(word_of(30'(16 + i)), 32'hFFFFFFFF);
        end
        @(posedge clock);
        `CHK("rd_valid", 1'b0, rd_valid)
        $display("done t_fifo");
    endtask : t_fifo

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        rd_ready = 1'b0;
        width_sel = 2'h0;
        wait_cyc = 4'h0;
        exp_base = '0;
        exp_wdata = '0;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_widths();
        t_mixed();
        t_writes();
        t_rmw();
        t_fifo();
        summarize();
    end
endmodule : dbs_lane_mux_tb
